// ### bpwm_regs.vh
// Register offsets, field positions, reset values and timing counts for the
// buffered PWM generator. Definitions only; included by the design file.
`ifndef BPWM_REGS_VH
`define BPWM_REGS_VH

// Register byte offsets on the APB bus (one aligned word each)
`define BPWM_OFF_TIMER_COUNT 12'h000
`define BPWM_OFF_TIMER_PERIOD 12'h004
`define BPWM_OFF_TIMER_CONTROL 12'h008
`define BPWM_OFF_DUTY_LOW 12'h00C
`define BPWM_OFF_DUTY_HIGH 12'h010
`define BPWM_OFF_UNIT_CONTROL 12'h014

// Timer control fields
`define BPWM_TCON_PRESCALE_LSB 0
`define BPWM_TCON_ENABLE_BIT 2
`define BPWM_TCON_POSTSCALE_LSB 3
`define BPWM_TCON_MASK 8'h7F

// Unit control fields
`define BPWM_UCON_MODE_LSB 0
`define BPWM_UCON_DUTY_BITS_LSB 4
`define BPWM_UCON_MASK 8'h3F
`define BPWM_MODE_PWM_TOP 2'h3

// Reset values
`define BPWM_RESET_PERIOD 8'hFF
`define BPWM_RESET_BYTE 8'h00

// Oscillator periods per timer increment at prescale 1
`define BPWM_QUARTER_CYCLES 4

`endif

// ### bpwm_top.v
// Buffered PWM generator: 8-bit time base, period register, double-buffered
// 10-bit duty compare and one output pin, programmed over APB.
// Assumes a single clock used as the oscillator and an APB master.
//
// Summary of operation
// R01: Period is (period+1) times 4 clocks times the prescale.
// R02: Timer equal to period clears on next increment, new period starts.
// R03: Output goes high at each period start unless duty is zero.
// R04: Duty low byte and bits copied into active buffer at period end.
// R05: Postscaler setting never changes PWM period or frequency.
// R06: Duty is 10 bits: low-byte register high eight, control bits 5:4 low.
// R07: High time equals duty times one clock times the prescale.
// R08: Duty writes accepted any time, effective only from next period.
// R09: Duty high byte is read-only in PWM mode, shows active duty.
// R10: Active duty held in high byte plus hidden 2-bit latch.
// R11: Output cleared when active duty equals timer with two extension bits.
// R12: Duty above period never clears the output in that period.
// R13: Software writes period, duty, direction, prescale and enable, then mode.
// R14: Prescaler divides by 1, 4 or 16 as the timer control selects.
// R15: Usable resolution shrinks with shorter periods, log2 of clock ratio.
// R16: Clearing the unit control register forces the output latch low.
// R17: Software clears the pin direction bit so the output drives the pin.
// R18: Timer advances every 4 clocks times prescale, only while enabled.
// R19: Extension bits from phase counter at prescale 1, else prescaler bits.
`timescale 1ns/1ps
`include "bpwm_regs.vh"

module bpwm_top #(
  parameter ADDR_WIDTH = 12
) (
  input wire CLK_I,
  input wire RESET_N_I,
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [ADDR_WIDTH-1:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  output reg [31:0] PRDATA_O,
  output reg PREADY_O,
  output reg PSLVERR_O,
  output reg PWM_OUTPUT_PIN_O,
  output reg PWM_OUTPUT_EN_N_O
);

  reg [7:0] time_base_timer;
  reg [7:0] period_register;
  reg [6:0] timer_control_register;
  reg [7:0] duty_low_byte;
  reg [7:0] duty_high_byte;
  reg [1:0] duty_hidden_bits;
  reg [5:0] unit_control_register;
  reg pin_direction;
  reg [1:0] phase_count;
  reg [3:0] prescale_count;
  reg [31:0] next_prdata;
  reg next_slverr;
  reg [3:0] prescale_last;
  reg new_period;

  wire setup_phase;
  wire wr_en;
  wire [1:0] prescale_select;
  wire timer_enable_bit;
  wire pwm_mode;
  wire increment;
  wire period_match;
  wire [9:0] active_duty;
  wire [9:0] pending_duty;
  wire [1:0] ext_bits;
  wire [9:0] compare_value;

  // APB answers in the access cycle; setup cycle just loads the answer
  assign setup_phase = PSEL_I & ~PENABLE_I;
  assign wr_en = PSEL_I & PENABLE_I & PWRITE_I & PREADY_O;

  assign prescale_select = timer_control_register[1:0];
  assign timer_enable_bit = timer_control_register[`BPWM_TCON_ENABLE_BIT];
  assign pwm_mode = (unit_control_register[3:2] == `BPWM_MODE_PWM_TOP);

  // Prescale codes: 00 -> 1, 01 -> 4, 1x -> 16
  always @* begin
    case (prescale_select)
      2'h0: prescale_last = 4'h0;
      2'h1: prescale_last = 4'h3;
      default: prescale_last = 4'hF;
    endcase
  end

  // One timer increment every 4 clocks times the prescale
  assign increment = timer_enable_bit & (phase_count == 2'h3) &
    (prescale_count == prescale_last); // R18 R01 R14

  // Postscaler bits 6:3 are stored and read back only; no timer or output logic uses them
  assign period_match = (time_base_timer == period_register); // R02 R05

  assign active_duty = {duty_high_byte, duty_hidden_bits}; // R10
  assign pending_duty = {duty_low_byte,
    unit_control_register[5:4]}; // R06

  // Extension bits give quarter-timer-step resolution; each step must last
  // one prescale period, so the slice of the prescaler follows the ratio
  assign ext_bits = (prescale_select == 2'h0) ? phase_count :
    (prescale_select == 2'h1) ? prescale_count[1:0] :
    prescale_count[3:2]; // R19
  // Compare at clock granularity of the fine count: high time = duty*Tosc*pre
  assign compare_value = {time_base_timer, ext_bits}; // R11 R07 R15

  // Quarter-cycle phase and prescaler counters
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      phase_count <= 2'h0;
      prescale_count <= 4'h0;
    end else if (!timer_enable_bit) begin
      phase_count <= 2'h0;
      prescale_count <= 4'h0;
    end else if (phase_count == 2'h3) begin
      phase_count <= 2'h0;
      prescale_count <= (prescale_count == prescale_last) ? 4'h0 :
        prescale_count + 4'h1;
    end else begin
      phase_count <= phase_count + 2'h1;
    end
  end

  // Time base and period-end marker for the output stage
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      time_base_timer <= 8'h00;
      new_period <= 1'b0;
    end else begin
      new_period <= increment & period_match;
      if (wr_en && PADDR_I == `BPWM_OFF_TIMER_COUNT)
        time_base_timer <= PWDATA_I[7:0];
      else if (increment && period_match)
        time_base_timer <= 8'h00; // R02
      else if (increment)
        time_base_timer <= time_base_timer + 8'h01;
    end
  end

  // Active duty buffer loads at period end; outside PWM mode software can also write the high byte
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      duty_high_byte <= `BPWM_RESET_BYTE;
      duty_hidden_bits <= 2'h0;
    end else if (increment && period_match) begin
      duty_high_byte <= pending_duty[9:2]; // R04 R08
      duty_hidden_bits <= pending_duty[1:0]; // R04
    end else if (wr_en && !pwm_mode &&
                 PADDR_I == `BPWM_OFF_DUTY_HIGH) begin
      duty_high_byte <= PWDATA_I[7:0]; // R09
    end
  end

  // Software registers
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      period_register <= `BPWM_RESET_PERIOD;
      timer_control_register <= 7'h00;
      duty_low_byte <= `BPWM_RESET_BYTE;
      unit_control_register <= 6'h00;
      pin_direction <= 1'b1;
    end else if (wr_en) begin
      case (PADDR_I)
        `BPWM_OFF_TIMER_PERIOD: period_register <= PWDATA_I[7:0];
        `BPWM_OFF_TIMER_CONTROL: begin
          timer_control_register <= PWDATA_I[6:0];
          pin_direction <= PWDATA_I[7]; // R17
        end
        `BPWM_OFF_DUTY_LOW: duty_low_byte <= PWDATA_I[7:0]; // R08
        `BPWM_OFF_UNIT_CONTROL:
          unit_control_register <= PWDATA_I[5:0]; // R08
        default: pin_direction <= pin_direction;
      endcase
    end
  end

  // Output latch: set at period start, cleared on duty match
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      PWM_OUTPUT_PIN_O <= 1'b0;
    end else if (unit_control_register == 6'h00 || !pwm_mode) begin
      PWM_OUTPUT_PIN_O <= 1'b0; // R16
    end else if (new_period) begin
      // Fresh duty now in buffer; zero duty keeps the pin low
      PWM_OUTPUT_PIN_O <= (active_duty != 10'h000); // R03
    end else if (timer_enable_bit && compare_value == active_duty) begin
      // Never matches when duty exceeds the period count
      PWM_OUTPUT_PIN_O <= 1'b0; // R11 R12
    end
  end

  // Pin drive enable, active low, from the direction bit
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I)
      PWM_OUTPUT_EN_N_O <= 1'b1;
    else
      PWM_OUTPUT_EN_N_O <= pin_direction; // R17
  end

  // Read data mux and error for unmapped addresses
  always @* begin
    next_prdata = 32'h0000_0000;
    next_slverr = 1'b0;
    case (PADDR_I)
      `BPWM_OFF_TIMER_COUNT: next_prdata[7:0] = time_base_timer;
      `BPWM_OFF_TIMER_PERIOD: next_prdata[7:0] = period_register;
      `BPWM_OFF_TIMER_CONTROL:
        next_prdata[7:0] = {pin_direction, timer_control_register};
      `BPWM_OFF_DUTY_LOW: next_prdata[7:0] = duty_low_byte;
      `BPWM_OFF_DUTY_HIGH: next_prdata[7:0] = duty_high_byte; // R09
      `BPWM_OFF_UNIT_CONTROL:
        next_prdata[7:0] = {2'h0, unit_control_register};
      default: next_slverr = 1'b1;
    endcase
  end

  // APB slave: ready high in the access cycle, one wait-free cycle
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      PREADY_O <= 1'b0;
      PRDATA_O <= 32'h0000_0000;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O <= setup_phase;
      PSLVERR_O <= setup_phase & next_slverr;
      if (setup_phase && !PWRITE_I)
        PRDATA_O <= next_prdata;
    end
  end

endmodule // bpwm_top

// ### bpwm_top_sva.sv
// Checker for bpwm_top: APB answer timing and PWM pin relations.
// Sees only the top-level ports; bound to every bpwm_top below.
`timescale 1ns/1ps
module bpwm_top_sva #(parameter ADDR_WIDTH = 12) (
  input wire CLK_I,
  input wire RESET_N_I,
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [ADDR_WIDTH-1:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  input wire [31:0] PRDATA_O,
  input wire PREADY_O,
  input wire PSLVERR_O,
  input wire PWM_OUTPUT_PIN_O,
  input wire PWM_OUTPUT_EN_N_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  // Completed write; unit control cleared by such a write
  wire wr = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O;
  sequence s_setup; PSEL_I && !PENABLE_I; endsequence
  sequence s_off; wr && PADDR_I == 12'h014 && PWDATA_I[5:0] == 6'h00;
  endsequence
  property p_rdy; s_setup |=> PREADY_O; endproperty
  property p_rdyc; PREADY_O |-> $past(PSEL_I && !PENABLE_I); endproperty
  property p_rdy1; PREADY_O |=> !PREADY_O; endproperty
  property p_err; PSLVERR_O |-> PREADY_O; endproperty
  property p_rdhi; PREADY_O && !PWRITE_I |-> PRDATA_O[31:8] == 24'h00_0000;
  endproperty
  // Shortest period is four clocks, so no two rises closer
  property p_minper;
    $rose(PWM_OUTPUT_PIN_O) |=> (!$rose(PWM_OUTPUT_PIN_O))[*3];
  endproperty
  // Direction only moves after a software write
  property p_en; !$stable(PWM_OUTPUT_EN_N_O) |-> $past(wr) || $past(wr, 2);
  endproperty
  property p_off; s_off |=> ##2 !PWM_OUTPUT_PIN_O[*4]; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  a_rdyc: assert property (p_rdyc) else $error("ready without setup");
  a_rdy1: assert property (p_rdy1) else $error("ready held too long");
  a_err: assert property (p_err) else $error("error without ready");
  a_rdhi: assert property (p_rdhi) else $error("read upper bits set");
  a_minper: assert property (p_minper) else $error("period short");
  a_en: assert property (p_en) else $error("direction moved alone");
  a_off: assert property (p_off) else $error("pin high when off");
endmodule // bpwm_top_sva
bind bpwm_top bpwm_top_sva #(.ADDR_WIDTH(ADDR_WIDTH)) bpwm_top_sva_inst (
  .CLK_I, .RESET_N_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I,
  .PRDATA_O, .PREADY_O, .PSLVERR_O, .PWM_OUTPUT_PIN_O, .PWM_OUTPUT_EN_N_O);

// ### bpwm_load.sv
// External load on the PWM pin; measures high time and period.
// Assumes the bench clock; a released pin is pulled low.
`timescale 1ns/1ps
module bpwm_load (
  input wire clk_i,
  input wire pin_i,
  input wire en_n_i,
  output logic level_o,
  output int hi_o,
  output int per_o
);
  int hc;
  int pc;
  logic prv = 1'b0;
  // Pull-down wins while the pin is not driven
  assign level_o = en_n_i ? 1'b0 : pin_i;
  // High samples per pulse, samples between rises
  always @(posedge clk_i) begin
    prv <= level_o;
    pc <= (level_o && !prv) ? 1 : pc + 1;
    hc <= level_o ? hc + 1 : 0;
    if (level_o && !prv) per_o <= pc;
    if (!level_o && prv) hi_o <= hc;
  end
endmodule // bpwm_load

// ### bpwm_top_tb.sv
// Self-checking bench for bpwm_top with an external load model.
// Assumes the register map of bpwm_regs.vh and a wait-free APB slave.
`timescale 1ns/1ps
`include "bpwm_regs.vh"
module bpwm_top_tb;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, rerr, lvl;
  logic [11:0] addr = 0;
  logic [31:0] wdata = 0, rdata, prdata;
  logic prdy, perr, pin, en_n;
  int hi, per, n, err_total = 0, checked = 0;
  bpwm_top bpwm_top_inst (.CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(addr), .PWDATA_I(wdata),
    .PRDATA_O(prdata), .PREADY_O(prdy), .PSLVERR_O(perr),
    .PWM_OUTPUT_PIN_O(pin), .PWM_OUTPUT_EN_N_O(en_n));
  bpwm_load bpwm_load_inst (.clk_i(clk), .pin_i(pin), .en_n_i(en_n),
    .level_o(lvl), .hi_o(hi), .per_o(per));
  initial forever #10 clk = ~clk;
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  // One APB transfer, request held until ready is sampled
  task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (prdy !== 1'b1 && ++k < 20);
    chk("pready", 1, {31'h0, prdy});
    rdata = prdata;
    rerr = perr;
    psel <= 0;
    pen <= 0;
  endtask
  task automatic rd(string nm, logic [11:0] a, logic [31:0] e);
    xfer(0, a, 0);
    chk(nm, e, rdata);
  endtask
  // Level samples over 300 cycles once settled
  task automatic cnt;
    repeat (600) @(posedge clk);
    n = 0;
    repeat (300) begin
      @(posedge clk);
      n += lvl;
    end
  endtask
  task t_reset;
    rd("period", `BPWM_OFF_TIMER_PERIOD, 32'h0000_00FF);
    rd("tcon", `BPWM_OFF_TIMER_CONTROL, 32'h0000_0080);
    rd("gap", 12'h018, 32'h0000_0000);
    chk("slverr", 1, {31'h0, rerr});
    $display("t_reset done");
  endtask
  // Period 4, duty 9, all prescales, postscale varied
  task t_pwm;
    int p;
    xfer(1, `BPWM_OFF_TIMER_PERIOD, 32'h0000_0003);
    xfer(1, `BPWM_OFF_DUTY_LOW, 32'h0000_0002);
    xfer(1, `BPWM_OFF_UNIT_CONTROL, 32'h0000_0010);
    for (int k = 0; k < 3; k++) begin
      p = 1 << (2 * k);
      xfer(1, `BPWM_OFF_TIMER_CONTROL, 32'h0000_0004 | k | (k << 5));
      xfer(1, `BPWM_OFF_UNIT_CONTROL, 32'h0000_001C);
      repeat (48 * p) @(posedge clk);
      chk("period", 16 * p, per);
      chk("high", 9 * p, hi);
    end
    rd("dutyhi", `BPWM_OFF_DUTY_HIGH, 32'h0000_0002);
    $display("t_pwm done");
  endtask
  // New duty waits for the period end
  task t_dbuf;
    @(posedge lvl);
    xfer(1, `BPWM_OFF_DUTY_HIGH, 32'h0000_00AA);
    xfer(1, `BPWM_OFF_DUTY_LOW, 32'h0000_0003);
    rd("held", `BPWM_OFF_DUTY_HIGH, 32'h0000_0002);
    repeat (600) @(posedge clk);
    rd("loaded", `BPWM_OFF_DUTY_HIGH, 32'h0000_0003);
    chk("high2", 13 * 16, hi);
    $display("t_dbuf done");
  endtask
  // Duty over period, duty zero, unit off
  task t_edge;
    xfer(1, `BPWM_OFF_DUTY_LOW, 32'h0000_00FF);
    xfer(1, `BPWM_OFF_UNIT_CONTROL, 32'h0000_003C);
    cnt;
    chk("over", 300, n);
    xfer(1, `BPWM_OFF_DUTY_LOW, 32'h0000_0000);
    xfer(1, `BPWM_OFF_UNIT_CONTROL, 32'h0000_000C);
    cnt;
    chk("zero", 0, n);
    xfer(1, `BPWM_OFF_DUTY_LOW, 32'h0000_00FF);
    xfer(1, `BPWM_OFF_UNIT_CONTROL, 32'h0000_0000);
    cnt;
    chk("off", 0, n);
    $display("t_edge done");
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #1_000_000;
    err_total++;
    print_verdict;
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1;
    t_reset;
    t_pwm;
    t_dbuf;
    t_edge;
    print_verdict;
  end
endmodule // bpwm_top_tb
